// File: core/tx_and_hw_config_regs.sv
// transmit configuration and hardware configuration register bank
`timescale 1ns/10ps
// What this block does
// - status flush clears status FIFO pointers, self-clears
// - data flush clears data FIFO pointers, self-clears
// - full status FIFO suspends unless overrun allowed
// - status full interrupt ignores overrun allow
// - transmit enable lets queued data go out
// - enable clears itself after stop and halt
// - stop finishes current frame, then halts
// - stop self-clears; writes ignored while set
// - read-only bit shows crossover strap state
// - fifo size field in kilobytes, max 14
// - status FIFO 512 bytes, data gets rest
// - receive side takes remainder of 16KB
// - read-only bit shows bus width strap
// - soft reset without PHY clocks times out
// - soft reset clears registers except kept bits
// - soft reset clears latched tx/rx errors
// - writes ignored until first read after reset
module tx_and_hw_config_regs
  import txhw_pkg::*;
#(
  parameter int SR_TIMEOUT_CYCLES = SR_TIMEOUT_CYC
) (
  input wire logic CLK_SYS,
  input wire logic SOFT_RESET_BIT,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] WDATA,
  output logic [31:0] RDATA,
  // strap and PHY clock status pins
  input wire logic XOVER_STRAP,
  input wire logic BUS_WIDTH_STRAP,
  input wire logic PHY_RX_CLK_OK,
  input wire logic PHY_TX_CLK_OK,
  // power save return, same clock
  input wire logic WAKE_EVENT,
  // transmitter handshake
  input wire logic TX_FRAME_ACTIVE,
  input wire logic TX_STS_FULL,
  output logic TX_RUN,
  output logic TX_STOPPED,
  output logic TX_STS_FULL_IRQ,
  output logic TX_STS_PTR_CLR,
  output logic TX_DATA_PTR_CLR,
  // latched error inputs
  input wire logic TX_ERR_EVENT,
  input wire logic RX_ERR_EVENT,
  output logic TX_ERR,
  output logic RX_ERR,
  // allocation outputs and soft reset pulse
  output logic [14:0] TX_DATA_BYTES,
  output logic [14:0] TX_STATUS_BYTES,
  output logic [14:0] RX_TOTAL_BYTES,
  output logic MAC_SOFT_RESET
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pins_s;
  txhw_sync #(.W(4)) u_sync (
    .clk(CLK_SYS),
    .rst(SOFT_RESET_BIT),
    .d({XOVER_STRAP, BUS_WIDTH_STRAP, PHY_RX_CLK_OK, PHY_TX_CLK_OK}),
    .q(pins_s)
  );
  logic phy_clks_ok;
  assign phy_clks_ok = pins_s[1] & pins_s[0];

  // ****************************************
  // strap capture after release
  // ****************************************
  logic [2:0] strap_wait_q;
  logic xover_q;
  logic bus32_q;
  logic strap_open;
  assign strap_open = (strap_wait_q != 3'h3);

  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT) begin
      strap_wait_q <= 3'h0;
    end else if (strap_open) begin
      strap_wait_q <= strap_wait_q + 3'h1;
    end
  end

  // wait until synchroniser holds pin value before latching
  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT) begin
      xover_q <= 1'b0;
      bus32_q <= 1'b0;
    end else if (strap_open) begin
      xover_q <= pins_s[3];
      bus32_q <= pins_s[2];
    end
  end

  // ****************************************
  // first-read write gate
  // ****************************************
  typedef enum logic [2:0] {
    SR_IDLE = 3'b001,
    SR_WAIT = 3'b010,
    SR_PULSE = 3'b100
  } sr_state_e;
  sr_state_e sr_q;
  logic soft_rst;
  logic wr_open_q;
  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT) begin
      wr_open_q <= 1'b0;
    end else if (soft_rst || WAKE_EVENT) begin
      wr_open_q <= 1'b0;
    end else if (RD) begin
      wr_open_q <= 1'b1;
    end
  end

  // one decode shared by the write strobes and the read mux
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  logic wr_tx;
  logic wr_hw;
  assign wr_tx = WR && wr_open_q && addr_hit(ADDR, OFF_TX_CONF);
  assign wr_hw = WR && wr_open_q && addr_hit(ADDR, OFF_HW_CONF);

  // ****************************************
  // transmit configuration
  // ****************************************
  logic ovr_allow_q;
  logic tx_en_q;
  logic stop_q;
  logic halted;
  // halted once no frame is in flight after a stop request
  assign halted = stop_q && !TX_FRAME_ACTIVE;

  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT || soft_rst) begin
      ovr_allow_q <= 1'b0;
    end else if (wr_tx) begin
      ovr_allow_q <= WDATA[TXC_OVR_ALLOW];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT || soft_rst) begin
      tx_en_q <= 1'b0;
    end else if (halted) begin
      tx_en_q <= 1'b0;
    end else if (wr_tx) begin
      tx_en_q <= WDATA[TXC_TX_ENABLE];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT || soft_rst) begin
      stop_q <= 1'b0;
    end else if (halted) begin
      stop_q <= 1'b0;
    end else if (wr_tx && !stop_q && WDATA[TXC_STOP]) begin
      // writes while set are dropped
      stop_q <= 1'b1;
    end
  end

  // flush strobes: one cycle per flush write, four cycles while soft reset pulses; the register bit reads back as zero
  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT) begin
      TX_STS_PTR_CLR <= 1'b0;
    end else begin
      TX_STS_PTR_CLR <= soft_rst || (wr_tx && WDATA[TXC_STS_FLUSH]);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT) begin
      TX_DATA_PTR_CLR <= 1'b0;
    end else begin
      TX_DATA_PTR_CLR <= soft_rst || (wr_tx && WDATA[TXC_DATA_FLUSH]);
    end
  end

  // a full status FIFO drops TX_RUN at once, even mid-frame, unless overrun allowed
  assign TX_RUN = tx_en_q && !(TX_STS_FULL && !ovr_allow_q) && !halted;
  assign TX_STOPPED = !tx_en_q;
  assign TX_STS_FULL_IRQ = TX_STS_FULL;

  // ****************************************
  // hardware configuration
  // ****************************************
  logic mbo_q;
  logic [3:0] fsz_q;
  logic sr_to_q;
  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT || soft_rst) begin
      mbo_q <= 1'b0;
    end else if (wr_hw) begin
      mbo_q <= WDATA[HWC_MBO];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT || soft_rst) begin
      fsz_q <= FSZ_RESET;
    end else if (wr_hw) begin
      // values above the maximum are clamped
      if (WDATA[HWC_FSZ_MSB:HWC_FSZ_LSB] > FSZ_MAX) begin
        fsz_q <= FSZ_MAX;
      end else begin
        fsz_q <= WDATA[HWC_FSZ_MSB:HWC_FSZ_LSB];
      end
    end
  end

  function automatic logic [14:0] kb_to_bytes(input logic [3:0] kb);
    kb_to_bytes = {1'b0, kb, 10'h000};
  endfunction

  // at a size of 0 the data FIFO byte count would underflow; software must avoid it
  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT) begin
      TX_DATA_BYTES <= kb_to_bytes(FSZ_RESET) - TX_STS_BYTES;
    end else begin
      TX_DATA_BYTES <= kb_to_bytes(fsz_q) - TX_STS_BYTES;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT) begin
      TX_STATUS_BYTES <= TX_STS_BYTES;
    end else begin
      TX_STATUS_BYTES <= TX_STS_BYTES;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT) begin
      RX_TOTAL_BYTES <= TOTAL_BUF_BYTES - kb_to_bytes(FSZ_RESET);
    end else begin
      RX_TOTAL_BYTES <= TOTAL_BUF_BYTES - kb_to_bytes(fsz_q);
    end
  end

  // ****************************************
  // soft reset sequencer
  // ****************************************
  logic [15:0] sr_cnt_q;
  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT) begin
      sr_q <= SR_IDLE;
      sr_cnt_q <= 16'h0000;
      sr_to_q <= 1'b0;
    end else begin
      unique case (sr_q)
        SR_IDLE: begin
          if (wr_hw && WDATA[HWC_SR]) begin
            sr_q <= SR_WAIT;
            sr_cnt_q <= 16'h0000;
            sr_to_q <= 1'b0;
          end
        end
        SR_WAIT: begin
          if (phy_clks_ok) begin
            sr_q <= SR_PULSE;
            sr_cnt_q <= 16'h0000;
          end else if (sr_cnt_q == 16'(SR_TIMEOUT_CYCLES - 1)) begin
            sr_q <= SR_IDLE;
            sr_to_q <= 1'b1;
          end else begin
            sr_cnt_q <= sr_cnt_q + 16'h0001;
          end
        end
        SR_PULSE: begin
          if (sr_cnt_q == 16'(SR_PULSE_CYC - 1)) begin
            sr_q <= SR_IDLE;
          end else begin
            sr_cnt_q <= sr_cnt_q + 16'h0001;
          end
        end
      endcase
    end
  end
  assign soft_rst = (sr_q == SR_PULSE);
  assign MAC_SOFT_RESET = soft_rst;

  // ****************************************
  // latched errors
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT || soft_rst) begin
      TX_ERR <= 1'b0;
    end else begin
      TX_ERR <= TX_ERR || TX_ERR_EVENT;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT || soft_rst) begin
      RX_ERR <= 1'b0;
    end else begin
      RX_ERR <= RX_ERR || RX_ERR_EVENT;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_hit(ADDR, OFF_TX_CONF)) begin
      rd_mux[TXC_OVR_ALLOW] = ovr_allow_q;
      rd_mux[TXC_TX_ENABLE] = tx_en_q;
      rd_mux[TXC_STOP] = stop_q;
    end else if (addr_hit(ADDR, OFF_HW_CONF)) begin
      rd_mux[HWC_XOVER] = xover_q;
      rd_mux[HWC_MBO] = mbo_q;
      rd_mux[HWC_FSZ_MSB:HWC_FSZ_LSB] = fsz_q;
      rd_mux[HWC_BUS32] = bus32_q;
      rd_mux[HWC_SR_TO] = sr_to_q;
      rd_mux[HWC_SR] = (sr_q != SR_IDLE);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SOFT_RESET_BIT) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= rd_mux;
    end
  end

endmodule // tx_and_hw_config_regs

// File: core/txhw_pkg.sv
// constants for the transmit and hardware configuration register bank
package txhw_pkg;
  localparam logic [7:0] OFF_TX_CONF = 8'h70;
  localparam logic [7:0] OFF_HW_CONF = 8'h74;
  // transmit configuration fields
  localparam int TXC_STS_FLUSH = 15;
  localparam int TXC_DATA_FLUSH = 14;
  localparam int TXC_OVR_ALLOW = 2;
  localparam int TXC_TX_ENABLE = 1;
  localparam int TXC_STOP = 0;
  // hardware configuration fields
  localparam int HWC_XOVER = 24;
  localparam int HWC_MBO = 20;
  localparam int HWC_FSZ_LSB = 16;
  localparam int HWC_FSZ_MSB = 19;
  localparam int HWC_BUS32 = 2;
  localparam int HWC_SR_TO = 1;
  localparam int HWC_SR = 0;
  localparam logic [3:0] FSZ_RESET = 4'h5;
  localparam logic [3:0] FSZ_MAX = 4'hE;
  localparam logic [3:0] FSZ_MIN = 4'h2;
  // buffer geometry in bytes
  localparam logic [14:0] TOTAL_BUF_BYTES = 15'h4000;
  localparam logic [14:0] TX_STS_BYTES = 15'h0200;
  localparam logic [14:0] KB_BYTES = 15'h0400;
  // soft reset timing
  localparam int SR_TIMEOUT_US = 100;
  localparam int CLK_MHZ = 10;
  localparam int SR_TIMEOUT_CYC = SR_TIMEOUT_US * CLK_MHZ;
  localparam int SR_PULSE_CYC = 4;
endpackage

// File: core/txhw_sync.sv
// two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/10ps
module txhw_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // txhw_sync

// File: test/txhw_chk.sv
// assertion checker for the tx and hw configuration register bank
`timescale 1ns/10ps
module txhw_chk (
  input wire logic CLK_SYS,
  input wire logic SOFT_RESET_BIT,
  input wire logic TX_STS_FULL,
  input wire logic TX_RUN,
  input wire logic TX_STOPPED,
  input wire logic TX_STS_FULL_IRQ,
  input wire logic TX_STS_PTR_CLR,
  input wire logic TX_ERR,
  input wire logic RX_ERR,
  input wire logic [14:0] TX_DATA_BYTES,
  input wire logic [14:0] TX_STATUS_BYTES,
  input wire logic [14:0] RX_TOTAL_BYTES,
  input wire logic MAC_SOFT_RESET
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SOFT_RESET_BIT);
  a_irq_tracks_full: assert property (TX_STS_FULL_IRQ == TX_STS_FULL)
    else $error("irq differs from full");
  a_run_needs_enable: assert property (TX_RUN |-> !TX_STOPPED)
    else $error("run while disabled");
  a_status_size_fixed: assert property (TX_STATUS_BYTES == 15'h0200)
    else $error("status size wrong");
  a_alloc_total: assert property (16'(TX_DATA_BYTES) + 16'(TX_STATUS_BYTES)
    + 16'(RX_TOTAL_BYTES) == 16'h4000)
    else $error("allocation sum wrong");
  a_sr_pulse_len: assert property ($rose(MAC_SOFT_RESET)
    |-> MAC_SOFT_RESET[*4] ##1 !MAC_SOFT_RESET)
    else $error("soft reset pulse length");
  a_sr_clears_err: assert property (MAC_SOFT_RESET |=> !TX_ERR && !RX_ERR)
    else $error("errors kept over soft reset");
  a_err_sticky: assert property (TX_ERR && !MAC_SOFT_RESET |=> TX_ERR)
    else $error("error flag dropped");
  a_flush_one_cycle: assert property (TX_STS_PTR_CLR && !MAC_SOFT_RESET
    |=> !TX_STS_PTR_CLR)
    else $error("flush pulse too long");
  c_soft_reset: cover property ($rose(MAC_SOFT_RESET));
  c_flush: cover property (TX_STS_PTR_CLR);
  c_run_full: cover property (TX_STS_FULL && TX_RUN);
endmodule // txhw_chk

bind tx_and_hw_config_regs txhw_chk chk (.CLK_SYS(CLK_SYS), .SOFT_RESET_BIT(SOFT_RESET_BIT),
  .TX_STS_FULL(TX_STS_FULL), .TX_RUN(TX_RUN), .TX_STOPPED(TX_STOPPED),
  .TX_STS_FULL_IRQ(TX_STS_FULL_IRQ), .TX_STS_PTR_CLR(TX_STS_PTR_CLR),
  .TX_ERR(TX_ERR), .RX_ERR(RX_ERR), .TX_DATA_BYTES(TX_DATA_BYTES),
  .TX_STATUS_BYTES(TX_STATUS_BYTES), .RX_TOTAL_BYTES(RX_TOTAL_BYTES),
  .MAC_SOFT_RESET(MAC_SOFT_RESET));

// File: test/host_model.sv
// host model driving the register port on falling edges
`timescale 1ns/10ps
module host_model (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [31:0] wdata
);
  initial begin
    {wr, rd} = 2'b00;
    addr = 8'h00;
    wdata = 32'h0000_0000;
  end
  // released lines flip so stale values never look valid
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    d = rdata;
  endtask
endmodule // host_model

// File: test/tx_and_hw_config_regs_tb.sv
// self-checking bench for the tx and hw configuration register bank
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tx_and_hw_config_regs_tb;
  import txhw_pkg::*;
  int n_mismatch = 0;
  int comparisons = 0;
  logic clk, soft_reset_bit, xs, bs, rxok, txok, wake, fa, full, txev, rxev, wr, rd;
  logic run, stopped, irq, sclr, dclr, transmit_error, receive_error, msr;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [14:0] dbytes, sbytes, rbytes;
  // ***************
  // design and host
  // ***************
  tx_and_hw_config_regs #(.SR_TIMEOUT_CYCLES(20)) dut (.CLK_SYS(clk), .SOFT_RESET_BIT(soft_reset_bit),
    .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata), .RDATA(rdata), .XOVER_STRAP(xs),
    .BUS_WIDTH_STRAP(bs), .PHY_RX_CLK_OK(rxok), .PHY_TX_CLK_OK(txok),
    .WAKE_EVENT(wake), .TX_FRAME_ACTIVE(fa), .TX_STS_FULL(full), .TX_RUN(run),
    .TX_STOPPED(stopped), .TX_STS_FULL_IRQ(irq), .TX_STS_PTR_CLR(sclr),
    .TX_DATA_PTR_CLR(dclr), .TX_ERR_EVENT(txev), .RX_ERR_EVENT(rxev), .TX_ERR(transmit_error),
    .RX_ERR(receive_error), .TX_DATA_BYTES(dbytes), .TX_STATUS_BYTES(sbytes),
    .RX_TOTAL_BYTES(rbytes), .MAC_SOFT_RESET(msr));
  host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    {soft_reset_bit, xs, bs, rxok, txok} = 5'b11111;
    {wake, fa, full, txev, rxev} = 5'b00000;
    cyc(20);
    soft_reset_bit = 1'b0;
    cyc(8);
    host.wr_reg(OFF_TX_CONF, 32'h0000_0006);
    host.rd_reg(OFF_TX_CONF, rv);
    `CHK(rv, 32'h0000_0000)
    host.rd_reg(OFF_HW_CONF, rv);
    `CHK(rv, 32'h0105_0004)
    `CHK(rbytes, 15'h2C00)
    host.rd_reg(8'h78, rv);
    `CHK(rv, 32'h0000_0000)
    host.wr_reg(OFF_HW_CONF, 32'hFFFF_FFFC);
    host.rd_reg(OFF_HW_CONF, rv);
    `CHK(rv, 32'h011E_0004)
    for (int k = FSZ_MIN; k <= FSZ_MAX; k++) begin
      host.wr_reg(OFF_HW_CONF, 32'h0010_0000 | (32'(k) << 16));
      cyc(1);
      `CHK(dbytes, 15'(k * 1024 - 512))
      `CHK(rbytes, 15'(16384 - k * 1024))
      `CHK(sbytes, TX_STS_BYTES)
    end
    host.wr_reg(OFF_TX_CONF, 32'hFFFF_FFFE);
    `CHK({sclr, dclr}, 2'b11)
    host.rd_reg(OFF_TX_CONF, rv);
    `CHK(rv, 32'h0000_0006)
    full = 1'b1;
    cyc(1);
    `CHK({run, irq}, 2'b11)
    host.wr_reg(OFF_TX_CONF, 32'h0000_0002);
    `CHK({run, irq}, 2'b01)
    full = 1'b0;
    fa = 1'b1;
    host.wr_reg(OFF_TX_CONF, 32'h0000_0003);
    `CHK(run, 1'b1)
    host.wr_reg(OFF_TX_CONF, 32'h0000_0006);
    host.rd_reg(OFF_TX_CONF, rv);
    `CHK(rv, 32'h0000_0007)
    fa = 1'b0;
    cyc(2);
    host.rd_reg(OFF_TX_CONF, rv);
    `CHK(rv, 32'h0000_0004)
    `CHK({stopped, run}, 2'b10)
    {txev, rxev} = 2'b11;
    cyc(1);
    {txev, rxev} = 2'b00;
    cyc(1);
    `CHK({transmit_error, receive_error}, 2'b11)
    host.wr_reg(OFF_HW_CONF, 32'h0015_0001);
    cyc(1);
    `CHK(msr, 1'b1)
    cyc(11);
    `CHK({transmit_error, receive_error, msr}, 3'b000)
    host.rd_reg(OFF_HW_CONF, rv);
    `CHK(rv, 32'h0105_0004)
    host.rd_reg(OFF_TX_CONF, rv);
    `CHK(rv, 32'h0000_0000)
    rxok = 1'b0;
    host.wr_reg(OFF_HW_CONF, 32'h0015_0001);
    cyc(30);
    host.rd_reg(OFF_HW_CONF, rv);
    `CHK(rv & 32'h0000_0003, 32'h0000_0002)
    rxok = 1'b1;
    host.wr_reg(OFF_HW_CONF, 32'h0015_0001);
    cyc(12);
    host.rd_reg(OFF_HW_CONF, rv);
    `CHK(rv, 32'h0105_0004)
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    host.wr_reg(OFF_TX_CONF, 32'h0000_0004);
    host.rd_reg(OFF_TX_CONF, rv);
    `CHK(rv, 32'h0000_0000)
    summarize();
  end
endmodule // tx_and_hw_config_regs_tb
